// *** verilog/pic_pkg.sv ***
// Constants shared by the interrupt control/status block and its mailbox matcher
package pic_pkg;

   // Operation register window
   localparam int          PIC_OP_AW       = 6;
   localparam logic [5:0]  PIC_CSR_OFFS    = 6'h38;
   localparam logic [31:0] PIC_CSR_RST     = 32'h00000000;
   localparam logic [31:0] PIC_RDATA_NONE  = 32'h00000000;

   // Mailbox addressing from the add-on side
   localparam int          PIC_MB_IDX_W    = 2;
   localparam int          PIC_MB_BYTES    = 4;

   // Byte lanes of the register
   localparam int          PIC_LANE_FIFO   = 3;
   localparam int          PIC_LANE_FLAGS  = 2;
   localparam int          PIC_LANE_INEN   = 1;
   localparam int          PIC_LANE_OUTEN  = 0;

   // Field positions
   localparam int          PIC_FIFO_LSB    = 24;
   localparam int          PIC_IRQ_BIT     = 23;
   localparam int          PIC_FLG_LSB     = 16;
   localparam int          PIC_FLG_W       = 6;
   localparam int          PIC_EN_RD_BIT   = 15;
   localparam int          PIC_EN_WR_BIT   = 14;
   localparam int          PIC_EN_IMB_BIT  = 12;
   localparam int          PIC_IMB_SEL_LSB = 10;
   localparam int          PIC_IMB_BYT_LSB = 8;
   localparam int          PIC_EN_OMB_BIT  = 4;
   localparam int          PIC_OMB_SEL_LSB = 2;
   localparam int          PIC_OMB_BYT_LSB = 0;

   // Flag indices inside the six-bit cause vector (bit 21 down to 16)
   localparam int          PIC_F_TA        = 5;
   localparam int          PIC_F_MA        = 4;
   localparam int          PIC_F_RTC       = 3;
   localparam int          PIC_F_WTC       = 2;
   localparam int          PIC_F_IMB       = 1;
   localparam int          PIC_F_OMB       = 0;

endpackage : pic_pkg

// *** verilog/pic_mbox_match.sv ***
// Registered match of an add-on mailbox byte access against a selector
`timescale 1ns/1ps
module pic_mbox_match (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   // Add-on access
   input  wire logic                          strobe,
   input  wire logic [pic_pkg::PIC_MB_IDX_W-1:0] mb_idx,
   input  wire logic [pic_pkg::PIC_MB_BYTES-1:0] mb_be,
   // Selector from the control register
   input  wire logic                          enable,
   input  wire logic [1:0]                    sel_mb,
   input  wire logic [1:0]                    sel_byte,
   // Result
   output logic                               hit
);
   import pic_pkg::*;

   typedef struct packed {
      logic hit;
   } pic_match_s;

   pic_match_s st_q;
   pic_match_s st_d;

   always_comb begin
      st_d     = st_q;
      // Only the chosen byte of the chosen mailbox counts, and only when enabled
      st_d.hit = strobe && enable && (mb_idx == sel_mb) && mb_be[sel_byte];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign hit = st_q.hit;

endmodule : pic_mbox_match

// *** verilog/pic_ctrl_stat.sv ***
// Interrupt control/status register with latched causes and PCI interrupt output
//
// Notes on behaviour
// - Bit 23 reads OR of flags 19..16
// - Target abort as master sets bit 21
// - Unanswered master cycle sets bit 20
// - Read count reaching zero sets bit 19
// - Write count reaching zero sets bit 18
// - Selected incoming mailbox byte write sets 17
// - Selected outgoing mailbox byte read sets 16
// - Writing one clears flag; zero keeps it
// - Bit 15 enables read-complete interrupt
// - Bit 14 enables write-complete interrupt
// - Bit 12 enables incoming mailbox interrupt
// - Bits 11:10 pick incoming mailbox
// - Bits 9:8 pick incoming mailbox byte
// - Bits 31:24 hold FIFO/endian control
// - Register at offset 38h, resets to zero
// - Bits 3:2 pick outgoing mailbox
`timescale 1ns/1ps
module pic_ctrl_stat #(
   parameter int CNT_W = 32
) (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   // Operation register access
   input  wire logic [pic_pkg::PIC_OP_AW-1:0] op_addr,
   input  wire logic                          op_wr,
   input  wire logic                          op_rd,
   input  wire logic [3:0]                    op_be,
   input  wire logic [31:0]                   op_wdata,
   output logic      [31:0]                   op_rdata,
   output logic                               op_rvalid,
   // Bus master events
   input  wire logic                          target_abort_evt,
   input  wire logic                          master_abort_evt,
   input  wire logic [CNT_W-1:0]              master_read_byte_count,
   input  wire logic [CNT_W-1:0]              master_write_byte_count,
   // Add-on mailbox accesses
   input  wire logic                          aon_mb_wr,
   input  wire logic                          aon_mb_rd,
   input  wire logic [pic_pkg::PIC_MB_IDX_W-1:0] aon_mb_idx,
   input  wire logic [pic_pkg::PIC_MB_BYTES-1:0] aon_mb_be,
   // Outputs
   output logic [7:0]                         fifo_endian_ctrl,
   output logic                               pci_irq
);
   import pic_pkg::*;

   typedef struct packed {
      logic [7:0]           fifo;
      logic [PIC_FLG_W-1:0] flags;
      logic                 en_rd;
      logic                 en_wr;
      logic                 en_imb;
      logic [1:0]           imb_sel;
      logic [1:0]           imb_byte;
      logic                 en_omb;
      logic [1:0]           omb_sel;
      logic [1:0]           omb_byte;
      logic                 rcnt_nz;
      logic                 wcnt_nz;
      logic [31:0]          rdata;
      logic                 rvalid;
      logic                 irq;
   } pic_state_s;

   pic_state_s st_q;
   pic_state_s st_d;

   logic imb_hit;
   logic omb_hit;
   logic csr_sel;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Count reaching zero: was nonzero, is zero now
   function automatic logic reach_zero(input logic was_nz, input logic [CNT_W-1:0] cnt);
      reach_zero = was_nz && (cnt == '0);
   endfunction : reach_zero

   function automatic logic [31:0] csr_image(input pic_state_s s);
      logic [31:0] v;
      v = '0;
      v[PIC_FIFO_LSB +: 8]            = s.fifo;
      v[PIC_IRQ_BIT]                  = |s.flags[PIC_F_RTC:PIC_F_OMB];
      v[PIC_FLG_LSB +: PIC_FLG_W]     = s.flags;
      v[PIC_EN_RD_BIT]                = s.en_rd;
      v[PIC_EN_WR_BIT]                = s.en_wr;
      v[PIC_EN_IMB_BIT]               = s.en_imb;
      v[PIC_IMB_SEL_LSB +: 2]         = s.imb_sel;
      v[PIC_IMB_BYT_LSB +: 2]         = s.imb_byte;
      v[PIC_EN_OMB_BIT]               = s.en_omb;
      v[PIC_OMB_SEL_LSB +: 2]         = s.omb_sel;
      v[PIC_OMB_BYT_LSB +: 2]         = s.omb_byte;
      csr_image = v;
   endfunction : csr_image

   ////////////////////////////////////////////////////////////////////////////
   // Mailbox matchers

   pic_mbox_match u_imb_match (
      .clk      (clk),
      .rst_n    (rst_n),
      .strobe   (aon_mb_wr),
      .mb_idx   (aon_mb_idx),
      .mb_be    (aon_mb_be),
      .enable   (st_q.en_imb),
      .sel_mb   (st_q.imb_sel),
      .sel_byte (st_q.imb_byte),
      .hit      (imb_hit)
   );

   pic_mbox_match u_omb_match (
      .clk      (clk),
      .rst_n    (rst_n),
      .strobe   (aon_mb_rd),
      .mb_idx   (aon_mb_idx),
      .mb_be    (aon_mb_be),
      .enable   (st_q.en_omb),
      .sel_mb   (st_q.omb_sel),
      .sel_byte (st_q.omb_byte),
      .hit      (omb_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   assign csr_sel = (op_addr == PIC_CSR_OFFS);

   always_comb begin
      logic [PIC_FLG_W-1:0] set_v;
      logic [PIC_FLG_W-1:0] clr_v;
      set_v = '0;
      clr_v = '0;
      st_d  = st_q;

      set_v[PIC_F_TA]  = target_abort_evt;
      set_v[PIC_F_MA]  = master_abort_evt;
      set_v[PIC_F_RTC] = st_q.en_rd &&
                         reach_zero(st_q.rcnt_nz, master_read_byte_count);
      set_v[PIC_F_WTC] = st_q.en_wr &&
                         reach_zero(st_q.wcnt_nz, master_write_byte_count);
      set_v[PIC_F_IMB] = imb_hit;
      set_v[PIC_F_OMB] = omb_hit;

      st_d.rcnt_nz = (master_read_byte_count != '0);
      st_d.wcnt_nz = (master_write_byte_count != '0);

      if (op_wr && csr_sel) begin
         if (op_be[PIC_LANE_FIFO]) begin
            st_d.fifo = op_wdata[PIC_FIFO_LSB +: 8];
         end
         if (op_be[PIC_LANE_FLAGS]) begin
            clr_v = op_wdata[PIC_FLG_LSB +: PIC_FLG_W];
         end
         if (op_be[PIC_LANE_INEN]) begin
            st_d.en_rd    = op_wdata[PIC_EN_RD_BIT];
            st_d.en_wr    = op_wdata[PIC_EN_WR_BIT];
            st_d.en_imb   = op_wdata[PIC_EN_IMB_BIT];
            st_d.imb_sel  = op_wdata[PIC_IMB_SEL_LSB +: 2];
            st_d.imb_byte = op_wdata[PIC_IMB_BYT_LSB +: 2];
         end
         if (op_be[PIC_LANE_OUTEN]) begin
            st_d.en_omb   = op_wdata[PIC_EN_OMB_BIT];
            st_d.omb_sel  = op_wdata[PIC_OMB_SEL_LSB +: 2];
            st_d.omb_byte = op_wdata[PIC_OMB_BYT_LSB +: 2];
         end
      end

      // A cause arriving with its own clear is kept: set wins
      st_d.flags = (st_q.flags & ~clr_v) | set_v;

      st_d.rvalid = op_rd;
      if (op_rd && csr_sel) begin
         st_d.rdata = csr_image(st_q);
      end else if (op_rd) begin
         st_d.rdata = PIC_RDATA_NONE;
      end

      st_d.irq = |st_d.flags;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // Power-up image is all zero, so every state field clears
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign op_rdata         = st_q.rdata;
   assign op_rvalid        = st_q.rvalid;
   assign fifo_endian_ctrl = st_q.fifo;
   assign pci_irq          = st_q.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic csr_wr_flags;
   assign csr_wr_flags = op_wr && csr_sel && op_be[PIC_LANE_FLAGS];

   a_irq_asserted_or: assert property (
      op_rd && csr_sel |=> op_rdata[PIC_IRQ_BIT] == |$past(st_q.flags[PIC_F_RTC:PIC_F_OMB]))
      else $error("interrupt asserted bit does not match flags");

   a_target_abort_set: assert property (
      target_abort_evt |=> st_q.flags[PIC_F_TA])
      else $error("target abort not latched");

   a_master_abort_set: assert property (
      master_abort_evt |=> st_q.flags[PIC_F_MA])
      else $error("master abort not latched");

   a_read_done_set: assert property (
      st_q.en_rd && st_q.rcnt_nz && master_read_byte_count == '0 |=> st_q.flags[PIC_F_RTC])
      else $error("read count zero not latched");

   a_write_done_set: assert property (
      st_q.en_wr && st_q.wcnt_nz && master_write_byte_count == '0 |=> st_q.flags[PIC_F_WTC])
      else $error("write count zero not latched");

   a_in_mbox_set: assert property (
      aon_mb_wr && st_q.en_imb && aon_mb_idx == st_q.imb_sel && aon_mb_be[st_q.imb_byte]
      |=> ##1 st_q.flags[PIC_F_IMB])
      else $error("incoming mailbox event not latched");

   a_out_mbox_set: assert property (
      aon_mb_rd && st_q.en_omb && aon_mb_idx == st_q.omb_sel && aon_mb_be[st_q.omb_byte]
      |=> ##1 st_q.flags[PIC_F_OMB])
      else $error("outgoing mailbox event not latched");

   a_one_clears_flag: assert property (
      csr_wr_flags && op_wdata[PIC_FLG_LSB + PIC_F_MA] && !master_abort_evt
      |=> !st_q.flags[PIC_F_MA])
      else $error("write one did not clear flag");

   a_zero_keeps_flag: assert property (
      st_q.flags[PIC_F_TA] && !(csr_wr_flags && op_wdata[PIC_FLG_LSB + PIC_F_TA])
      |=> st_q.flags[PIC_F_TA])
      else $error("flag lost without a write of one");

   a_enable_store: assert property (
      op_wr && csr_sel && op_be[PIC_LANE_INEN] |=> op_rd && csr_sel
      |=> op_rdata[15:8] == ($past(op_wdata[15:8], 2) & 8'hDF))
      else $error("enable and selector fields not stored");

   a_fifo_byte_store: assert property (
      op_wr && csr_sel && op_be[PIC_LANE_FIFO] |=> fifo_endian_ctrl == $past(op_wdata[31:24]))
      else $error("fifo and endian byte not stored");

   a_unmapped_zero: assert property (
      op_rd && !csr_sel |=> op_rvalid && op_rdata == PIC_RDATA_NONE)
      else $error("unmapped read returned data");

   a_rsvd_zero: assert property (
      op_rd && csr_sel |=> op_rdata[22] == 1'b0 && op_rdata[13] == 1'b0 && op_rdata[7:5] == 3'h0)
      else $error("reserved bits read nonzero");

   a_irq_follows: assert property (
      pci_irq == |st_q.flags)
      else $error("interrupt output disagrees with flags");

   // Refused events: a disabled source must not raise its flag
   a_rtc_disabled: assert property (
      !st_q.en_rd && !st_q.flags[PIC_F_RTC] |=> !st_q.flags[PIC_F_RTC])
      else $error("read complete flag set while disabled");

   a_wtc_disabled: assert property (
      !st_q.en_wr && !st_q.flags[PIC_F_WTC] |=> !st_q.flags[PIC_F_WTC])
      else $error("write complete flag set while disabled");

   // Matcher adds a stage, so the enable is looked at one cycle earlier
   a_imb_disabled: assert property (
      !st_q.en_imb ##1 !st_q.flags[PIC_F_IMB] |=> !st_q.flags[PIC_F_IMB])
      else $error("incoming mailbox flag set while disabled");

   a_irq_on_abort: assert property (
      target_abort_evt || master_abort_evt |=> pci_irq)
      else $error("abort did not raise the interrupt");

   a_irq_stays_set: assert property (
      pci_irq && !csr_wr_flags |=> pci_irq)
      else $error("interrupt dropped without a clear");

   a_rvalid_answer: assert property (
      op_rd |=> op_rvalid)
      else $error("read not answered");

   a_rvalid_pulse: assert property (
      !op_rd |=> !op_rvalid)
      else $error("read valid without a read");

   c_irq_rise:   cover property ($rose(pci_irq));
   c_omb_event:  cover property ($rose(st_q.flags[PIC_F_OMB]));
   c_imb_event:  cover property ($rose(st_q.flags[PIC_F_IMB]));
   c_read_done:  cover property ($rose(st_q.flags[PIC_F_RTC]));
   c_irq_clear:  cover property (pci_irq ##1 csr_wr_flags ##1 !pci_irq);

endmodule : pic_ctrl_stat

// *** dv/pic_addon_model.sv ***
// Add-on side model: runs transfer counts down and makes mailbox accesses
`timescale 1ns/1ps
module pic_addon_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Command from the bench
   input  wire logic        go,
   input  wire logic [1:0]  kind,
   input  wire logic [1:0]  idx,
   input  wire logic [3:0]  be,
   // Far side signals
   output logic      [31:0] rd_cnt,
   output logic      [31:0] wr_cnt,
   output logic             mb_wr,
   output logic             mb_rd,
   output logic      [1:0]  mb_idx,
   output logic      [3:0]  mb_be
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_cnt <= 32'h0;
         wr_cnt <= 32'h0;
         mb_wr  <= 1'b0;
         mb_rd  <= 1'b0;
         mb_idx <= 2'h0;
         mb_be  <= 4'h0;
      end else begin
         mb_wr  <= go && kind == 2'h2;
         mb_rd  <= go && kind == 2'h3;
         // Released lines toggle so a stale value never matches by luck
         mb_idx <= go ? idx : ~mb_idx;
         mb_be  <= go ? be : ~mb_be;
         if (go && kind == 2'h0) rd_cnt <= 32'h5;
         else if (rd_cnt != 32'h0) rd_cnt <= rd_cnt - 32'h1;
         if (go && kind == 2'h1) wr_cnt <= 32'h5;
         else if (wr_cnt != 32'h0) wr_cnt <= wr_cnt - 32'h1;
      end
   end
endmodule : pic_addon_model

// *** dv/test_pci_interrupt_control_status.sv ***
// Self-checking bench for the interrupt control/status block
`timescale 1ns/1ps
module test_pci_interrupt_control_status;
   import pic_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, op_wr = 1'b0, op_rd = 1'b0, ta = 1'b0, ma = 1'b0;
   logic [5:0]  op_addr = 6'h0;
   logic [3:0]  op_be = 4'h0, be = 4'h0;
   logic [31:0] op_wdata = 32'h0, op_rdata, rd_cnt, wr_cnt, img, seed = 32'h42FE;
   logic        op_rvalid, go = 1'b0, mb_wr, mb_rd, pci_irq;
   logic [1:0]  kind = 2'h0, idx = 2'h0, mb_idx;
   logic [3:0]  mb_be;
   logic [7:0]  fec;
   logic [31:0] exp_q [$];
   int          num_errors = 0, n_compared = 0;
   localparam logic [5:0] CSR = PIC_CSR_OFFS;

   always #2 clk = ~clk;

   pic_ctrl_stat dut_u (.clk(clk), .rst_n(rst_n), .op_addr(op_addr), .op_wr(op_wr),
      .op_rd(op_rd), .op_be(op_be), .op_wdata(op_wdata), .op_rdata(op_rdata),
      .op_rvalid(op_rvalid), .target_abort_evt(ta), .master_abort_evt(ma),
      .master_read_byte_count(rd_cnt), .master_write_byte_count(wr_cnt),
      .aon_mb_wr(mb_wr), .aon_mb_rd(mb_rd), .aon_mb_idx(mb_idx), .aon_mb_be(mb_be),
      .fifo_endian_ctrl(fec), .pci_irq(pci_irq));

   pic_addon_model addon_u (.clk(clk), .rst_n(rst_n), .go(go), .kind(kind), .idx(idx),
      .be(be), .rd_cnt(rd_cnt), .wr_cnt(wr_cnt), .mb_wr(mb_wr), .mb_rd(mb_rd),
      .mb_idx(mb_idx), .mb_be(mb_be));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_val

   task automatic cmp_pin(input logic e);
      n_compared++;
      if (pci_irq !== e) begin
         num_errors++;
         $display("[ERR] pci_irq expected %b seen %b", e, pci_irq);
      end
   endtask : cmp_pin

   task automatic wr(input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
      @(posedge clk); #1;
      op_addr = a;
      op_be = b;
      op_wdata = d;
      op_wr = 1'b1;
      @(posedge clk); #1;
      op_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      @(posedge clk); #1;
      op_addr = a;
      op_rd = 1'b1;
      exp_q.push_back(e);
      @(posedge clk); #1;
      op_rd = 1'b0;
   endtask : rd

   // One far side command, then time for the flag to land
   task automatic ev(input logic [1:0] k, input logic [1:0] i, input logic [3:0] b);
      @(posedge clk); #1;
      kind = k;
      idx = i;
      be = b;
      go = 1'b1;
      @(posedge clk); #1;
      go = 1'b0;
      repeat (9) @(posedge clk);
   endtask : ev

   task automatic abort_pulse(input logic t);
      @(posedge clk); #1;
      ta = t;
      ma = !t;
      @(posedge clk); #1;
      ta = 1'b0;
      ma = 1'b0;
      @(posedge clk); #1;
   endtask : abort_pulse

   task automatic wrap_up;
      if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   // Read results are checked away from the edge that updates them
   always @(negedge clk) begin
      if (op_rvalid === 1'b1) begin
         if (exp_q.size() == 0) cmp_val("unexpected read", 32'h0, op_rdata);
         else cmp_val("op_rdata", exp_q.pop_front(), op_rdata);
      end
   end

   initial begin
      #100000;
      num_errors++;
      wrap_up();
   end

   initial begin
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      rd(CSR, PIC_CSR_RST);
      rd(6'h30, PIC_RDATA_NONE);
      wr(CSR, 4'hF, 32'hFFFFFFFF);
      rd(CSR, 32'hFF00DF1F);
      wr(6'h34, 4'hF, 32'h0);
      wr(CSR, 4'h8, 32'h5A000000);
      img = 32'h5A00DF1F;
      rd(CSR, img);
      cmp_val("fifo_endian_ctrl", 32'h5A, {24'h0, fec});
      abort_pulse(1'b1);
      cmp_pin(1'b1);
      abort_pulse(1'b0);
      rd(CSR, img | 32'h00300000);
      wr(CSR, 4'h4, 32'h0);
      rd(CSR, img | 32'h00300000);
      wr(CSR, 4'hB, 32'h00200000 | img);
      rd(CSR, img | 32'h00300000);
      wr(CSR, 4'h4, 32'h00200000);
      rd(CSR, img | 32'h00100000);
      wr(CSR, 4'h4, 32'h00100000);
      @(negedge clk) cmp_pin(1'b0);
      ev(2'h0, 2'h0, 4'h0);
      rd(CSR, img | 32'h00880000);
      wr(CSR, 4'h4, 32'h00080000);
      ev(2'h1, 2'h0, 4'h0);
      rd(CSR, img | 32'h00840000);
      wr(CSR, 4'h4, 32'h00040000);
      wr(CSR, 4'h3, 32'h00000F0F);
      img = 32'h5A000F0F;
      ev(2'h0, 2'h0, 4'h0);
      ev(2'h1, 2'h0, 4'h0);
      ev(2'h2, 2'h3, 4'h8);
      ev(2'h3, 2'h3, 4'h8);
      rd(CSR, img);
      @(negedge clk) cmp_pin(1'b0);
      for (int m = 0; m < 4; m++) begin
         for (int b = 0; b < 4; b++) begin
            seed = xs(seed);
            img = {8'h5A, 8'h00, 3'h6, 1'b1, m[1:0], b[1:0], 3'h0, 1'b1, m[1:0], b[1:0]};
            wr(CSR, 4'h3, img);
            ev(2'h2, m[1:0], ~(4'h1 << b) & seed[3:0]);
            ev(2'h2, m[1:0] + 2'h1 + seed[5:4] % 3, 4'hF);
            rd(CSR, img);
            ev(2'h2, m[1:0], (4'h1 << b) | seed[3:0]);
            rd(CSR, img | 32'h00820000);
            ev(2'h3, m[1:0], (4'h1 << b) | seed[7:4]);
            rd(CSR, img | 32'h00830000);
            cmp_pin(1'b1);
            wr(CSR, 4'h4, 32'h00030000);
            rd(CSR, img);
         end
      end
      // Let the last read answer be checked before reset wipes it
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      rd(CSR, PIC_CSR_RST);
      repeat (3) @(posedge clk);
      cmp_val("pending reads", 32'h0, exp_q.size());
      wrap_up();
   end
endmodule : test_pci_interrupt_control_status
